/* File: sim/dcfifo_chk.sv */
// Port checker for the dual-clock FIFO
`timescale 1ns/1ps
`default_nettype none
module dcfifo_chk
    import dcfifo_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic full_init_n,
    input wire logic partial_init_n,
    input wire logic outEnable_n,
    input wire logic rdDataOe,
    input wire logic [DCF_WIDTH-1:0] rd_data,
    input wire logic almost_full_n,
    input wire logic almost_empty_n,
    input wire logic half_level_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Bus drive follows output enable
    property p_oe_on; $fell(outEnable_n) |-> ##[1:4] rdDataOe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("data bus not driven");
    property p_oe_off; $rose(outEnable_n) |-> ##[1:4] !rdDataOe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("data bus not released");
    // Flag levels just after reset
    property p_rst; $rose(arst_n) |-> almost_full_n && half_level_n && !almost_empty_n; endproperty
    a_rst: assert property (p_rst) else $error("flags wrong after reset");
    // Full init clears data and flags
    property p_init_data; (!full_init_n) [*5] |-> rd_data == DCF_DATA_RESET; endproperty
    a_init_data: assert property (p_init_data) else $error("data not cleared");
    property p_init_ae; (!full_init_n) [*6] |-> !almost_empty_n; endproperty
    a_init_ae: assert property (p_init_ae) else $error("almost empty wrong");
    property p_init_half; (!full_init_n) [*6] |-> half_level_n; endproperty
    a_init_half: assert property (p_init_half) else $error("half level wrong");
    property p_init_af; (!full_init_n) [*6] |-> almost_full_n; endproperty
    a_init_af: assert property (p_init_af) else $error("almost full wrong");
    // Partial init clears data and count
    property p_pinit_data; (!partial_init_n) [*5] |-> rd_data == DCF_DATA_RESET; endproperty
    a_pinit_data: assert property (p_pinit_data) else $error("data kept on partial");
    property p_pinit_ae; (!partial_init_n) [*6] |-> !almost_empty_n && half_level_n; endproperty
    a_pinit_ae: assert property (p_pinit_ae) else $error("count kept on partial");
endmodule // dcfifo_chk
bind dcfifo_core dcfifo_chk u_chk (.clk(clk), .arst_n(arst_n), .full_init_n(full_init_n),
    .partial_init_n(partial_init_n), .outEnable_n(outEnable_n), .rdDataOe(rdDataOe),
    .rd_data(rd_data), .almost_full_n(almost_full_n), .almost_empty_n(almost_empty_n),
    .half_level_n(half_level_n));
`default_nettype wire

/* File: sim/dcfifo_core_test.sv */
// Self-checking bench for the dual-clock FIFO
`timescale 1ns/1ps
`default_nettype none
module dcfifo_core_test
    import dcfifo_pkg::*;
;
    logic clk = 1'b0, arst_n = 1'b0, full_init_n = 1'b1, partial_init_n = 1'b1;
    logic wrEnable_n = 1'b1, bit_load_enable_n = 1'b1, fallthrough_sel_serial_in = 1'b0;
    logic offset_access_n = 1'b1, rdEnable_n = 1'b1, reread_n = 1'b1, outEnable_n = 1'b1;
    logic [17:0] wr_data = 18'h00000, rd_data, v, w;
    logic wrClk, rdClk, rdDataOe, fir, eor, almost_full_n, almost_empty_n, half_level_n;
    int failures = 0, comparisons = 0;
    // System clock, 40 ns
    always #20 clk = ~clk;
    dcfifo_link LNK (.wrClk(wrClk), .rdClk(rdClk));
    dcfifo_core DUT (.clk(clk), .arst_n(arst_n), .full_init_n(full_init_n),
        .partial_init_n(partial_init_n), .wrClk(wrClk), .wrEnable_n(wrEnable_n),
        .wr_data(wr_data), .bit_load_enable_n(bit_load_enable_n),
        .fallthrough_sel_serial_in(fallthrough_sel_serial_in),
        .offset_access_n(offset_access_n), .rdClk(rdClk), .rdEnable_n(rdEnable_n),
        .reread_n(reread_n), .outEnable_n(outEnable_n), .rd_data(rd_data),
        .rdDataOe(rdDataOe), .full_or_input_ready(fir), .empty_or_output_ready(eor),
        .almost_full_n(almost_full_n), .almost_empty_n(almost_empty_n),
        .half_level_n(half_level_n));
    // Compare and count
    task chk(input string nm, input logic [17:0] s, input logic [17:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task settle;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task init(input logic sel);
        @(posedge clk);
        full_init_n <= 1'b0;
        fallthrough_sel_serial_in <= sel;
        repeat (6) @(posedge clk);
        full_init_n <= 1'b1;
        repeat (4) @(posedge clk);
        fallthrough_sel_serial_in <= 1'b0;
    endtask
    task wr(input logic [17:0] d);
        @(negedge wrClk);
        @(posedge clk);
        wrEnable_n <= 1'b0;
        wr_data <= d;
        @(posedge wrClk);
        repeat (6) @(posedge clk);
        wrEnable_n <= 1'b1;
    endtask
    task rd(input logic en_n, input logic rr_n, input logic ld_n, output logic [17:0] q);
        @(negedge rdClk);
        @(posedge clk);
        rdEnable_n <= en_n;
        reread_n <= rr_n;
        offset_access_n <= ld_n;
        @(posedge rdClk);
        repeat (6) @(posedge clk);
        #1 q = rd_data;
        @(posedge clk);
        rdEnable_n <= 1'b1;
        reread_n <= 1'b1;
        offset_access_n <= 1'b1;
    endtask
    task conclude;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #500000;
        failures++;
        conclude;
    end
    // Test sequence
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        init(1'b0);
        settle;
        chk("empty", 18'(eor), 18'h00000);
        chk("full", 18'(fir), 18'h00001);
        chk("data", rd_data, DCF_DATA_RESET);
        rd(1'b0, 1'b1, 1'b1, v);
        chk("empty read", v, DCF_DATA_RESET);
        for (int i = 0; i < 3; i++) wr(18'h2a5a0 + 18'(i));
        settle;
        chk("empty", 18'(eor), 18'h00001);
        chk("almost empty", 18'(almost_empty_n), 18'h00000);
        chk("almost full", 18'(almost_full_n), 18'h00001);
        chk("half", 18'(half_level_n), 18'h00001);
        for (int i = 0; i < 3; i++) begin
            rd(1'b0, 1'b1, 1'b1, v);
            chk("word", v, 18'h2a5a0 + 18'(i));
        end
        settle;
        chk("empty", 18'(eor), 18'h00000);
        rd(1'b1, 1'b0, 1'b1, v);
        rd(1'b0, 1'b1, 1'b1, v);
        chk("reread", v, 18'h2a5a0);
        rd(1'b0, 1'b1, 1'b0, v);
        rd(1'b0, 1'b1, 1'b0, w);
        chk("default", v, DCF_OFFSET_FAR);
        chk("offsets", w, DCF_OFFSET_FAR);
        $display("standard test done");
        @(posedge clk);
        partial_init_n <= 1'b0;
        repeat (6) @(posedge clk);
        partial_init_n <= 1'b1;
        settle;
        chk("data", rd_data, DCF_DATA_RESET);
        chk("empty", 18'(eor), 18'h00000);
        rd(1'b0, 1'b1, 1'b0, w);
        chk("kept", w, v);
        outEnable_n <= 1'b0;
        settle;
        chk("oe", 18'(rdDataOe), 18'h00001);
        @(posedge clk);
        outEnable_n <= 1'b1;
        settle;
        chk("oe", 18'(rdDataOe), 18'h00000);
        $display("partial test done");
        init(1'b1);
        settle;
        chk("in ready", 18'(fir), 18'h00000);
        chk("out ready", 18'(eor), 18'h00001);
        wr(18'h15a5a);
        repeat (4) @(posedge rdClk);
        settle;
        chk("fall word", rd_data, 18'h15a5a);
        chk("out ready", 18'(eor), 18'h00000);
        rd(1'b0, 1'b1, 1'b1, v);
        settle;
        chk("out ready", 18'(eor), 18'h00001);
        $display("fall-through test done");
        conclude;
    end
endmodule // dcfifo_core_test
`default_nettype wire

/* File: sim/dcfifo_link.sv */
// Far-side write and read link clocks
`timescale 1ns/1ps
`default_nettype none
module dcfifo_link (
    output logic wrClk,
    output logic rdClk
);
    // Write clock, 320 ns period
    initial begin
        wrClk = 1'b0;
        forever #160 wrClk = ~wrClk;
    end
    // Read clock, same rate, unrelated phase
    initial begin
        rdClk = 1'b0;
        #70;
        forever #160 rdClk = ~rdClk;
    end
endmodule // dcfifo_link
`default_nettype wire

/* File: verilog/dcfifo_core.sv */
// Dual-clock 18-bit FIFO with programmable almost-full/almost-empty flags
// Behaviour
// - 18-bit input and output, one word per edge
// - Full init zeroes pointers and output register
// - Full init latches mode, default offset, method
// - Partial init zeroes pointers, keeps settings
// - Reread returns read pointer to zero
// - Reread forces empty low or ready high
// - Mode pin level at full init picks timing
// - After full init mode pin is serial input
// - Enabled write stores word or parallel offset
// - Serial load shifts one offset bit per edge
// - Enabled read presents word or offset value
// - Output enable drives or releases data bus
// - Offset access level picks 127 or 1023 default
// - Offset access redirects writes and reads
// - Standard mode: full flag on memory full
// - Fall-through mode: input ready when space
// - Standard mode: empty flag on memory empty
// - Fall-through mode: ready when word presented
// - Almost-full low above capacity minus m
// - Almost-empty low below n words
// - Half level shows above or below half
// - Depth 131072 or 262144 words
// - First fall-through word appears unrequested
// - Read enable active low for further words
// - Default 127 parallel, 1023 serial
//
`timescale 1ns/1ps
`default_nettype none
module dcfifo_core
    import dcfifo_pkg::*;
#(
    parameter int DEPTH = DCF_DEPTH_SMALL
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic full_init_n,
    input wire logic partial_init_n,
    input wire logic wrClk,
    input wire logic wrEnable_n,
    input wire logic [DCF_WIDTH-1:0] wr_data,
    input wire logic bit_load_enable_n,
    input wire logic fallthrough_sel_serial_in,
    input wire logic offset_access_n,
    input wire logic rdClk,
    input wire logic rdEnable_n,
    input wire logic reread_n,
    input wire logic outEnable_n,
    output logic [DCF_WIDTH-1:0] rd_data,
    output logic rdDataOe,
    output logic full_or_input_ready,
    output logic empty_or_output_ready,
    output logic almost_full_n,
    output logic almost_empty_n,
    output logic half_level_n
);
    localparam int AW = $clog2(DEPTH);
    localparam int OW = (AW > DCF_WIDTH) ? AW : DCF_WIDTH;

    // only the two documented depths
    // Refused at elaboration, other depths break the flag maths
    if (DEPTH != DCF_DEPTH_SMALL && DEPTH != DCF_DEPTH_LARGE) begin : g_badDepth
        $error("DEPTH must be 131072 or 262144");
    end

    // Two-stage synchronisers for every outside input
    localparam int NS = 12 + DCF_WIDTH;
    // Idle levels so nothing looks active straight after reset
    localparam logic [NS-1:0] SYNC_IDLE = {DCF_SYNC_IDLE_CTRL, {DCF_WIDTH{1'b0}}};
    logic [NS-1:0] asyncIn;
    logic [NS-1:0] sync1_r;
    logic [NS-1:0] sync2_r;
    assign asyncIn = {full_init_n, partial_init_n, wrClk, wrEnable_n, bit_load_enable_n,
        fallthrough_sel_serial_in, offset_access_n, rdClk, rdEnable_n, reread_n,
        outEnable_n, 1'b0, wr_data};

    // One synchroniser pair per pin bit
    for (genvar gi = 0; gi < NS; gi++) begin : g_sync
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                sync1_r[gi] <= SYNC_IDLE[gi];
                sync2_r[gi] <= SYNC_IDLE[gi];
            end else begin
                sync1_r[gi] <= asyncIn[gi];
                sync2_r[gi] <= sync1_r[gi];
            end
        end
    end
    logic fInitN, pInitN, wClkS, wEnN, sEnN, serIn, ldN, rClkS, rEnN, rtN, oeN;
    logic [DCF_WIDTH-1:0] wData;
    assign {fInitN, pInitN, wClkS, wEnN, sEnN, serIn, ldN, rClkS, rEnN, rtN, oeN} =
        sync2_r[NS-1:DCF_WIDTH+1];
    assign wData = sync2_r[DCF_WIDTH-1:0];

    // Edge finders on the sampled link clocks
    logic wClkPrev_r, rClkPrev_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wClkPrev_r <= 1'b0;
            rClkPrev_r <= 1'b0;
        end else begin
            wClkPrev_r <= wClkS;
            rClkPrev_r <= rClkS;
        end
    end
    logic wEdge, rEdge;
    assign wEdge = wClkS && !wClkPrev_r;
    assign rEdge = rClkS && !rClkPrev_r;

    logic ftMode_r, serialMode_r;
    // Timing mode, held until the next full init
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ftMode_r <= 1'b0;
        end else if (!fInitN) begin
            ftMode_r <= serIn;
        end
    end

    // Offset programming method, held likewise
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            serialMode_r <= 1'b0;
        end else if (!fInitN) begin
            serialMode_r <= ldN;
        end
    end

    logic initAny;
    assign initAny = !fInitN || !pInitN;

    // Pointers one bit wider than the address for wrap detection
    logic [AW:0] wPtr_r, rPtr_r;
    logic [AW:0] count;
    logic fullNow, emptyNow;
    assign count = wPtr_r - rPtr_r;
    assign fullNow = count == (AW+1)'(DEPTH);
    assign emptyNow = count == '0;

    // Offset registers: empty offset n, full offset m
    logic [OW-1:0] offEmpty_r, offFull_r;
    logic offSel_r;   // Next parallel target: 0 empty, 1 full
    logic offRdSel_r;
    logic [AW:0] shiftCnt_r;

    logic wrMem, wrOff, wrSer;
    assign wrOff = wEdge && !wEnN && !ldN && !serialMode_r;
    assign wrSer = wEdge && !sEnN && !ldN && serialMode_r;
    assign wrMem = wEdge && !wEnN && ldN && !fullNow;

    // Serial loading fills the empty offset first, then the full offset
    logic serToEmpty;
    assign serToEmpty = shiftCnt_r < (AW+1)'(AW);

    // partial init leaves the empty offset alone
    // Empty offset: default at full init, then parallel or serial load
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            offEmpty_r <= OW'(DCF_OFFSET_NEAR);
        end else if (!fInitN) begin
            offEmpty_r <= ldN ? OW'(DCF_OFFSET_FAR) : OW'(DCF_OFFSET_NEAR);
        end else if (wrOff && !offSel_r) begin
            offEmpty_r <= OW'(wData);
        end else if (wrSer && serToEmpty) begin
            // New bit enters at the top of the AW-bit field, LSB first
            offEmpty_r <= {serIn, offEmpty_r[OW-1:1]} >> (OW - AW);
        end
    end

    // Full offset: same scheme, second in each pair
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            offFull_r <= OW'(DCF_OFFSET_NEAR);
        end else if (!fInitN) begin
            offFull_r <= ldN ? OW'(DCF_OFFSET_FAR) : OW'(DCF_OFFSET_NEAR);
        end else if (wrOff && offSel_r) begin
            offFull_r <= OW'(wData);
        end else if (wrSer && !serToEmpty) begin
            offFull_r <= {serIn, offFull_r[OW-1:1]} >> (OW - AW);
        end
    end

    // Parallel target toggles with every offset word
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            offSel_r <= 1'b0;
        end else if (!fInitN) begin
            offSel_r <= 1'b0;
        end else if (wrOff) begin
            offSel_r <= !offSel_r;
        end
    end

    // serial bit counter over both offsets
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shiftCnt_r <= '0;
        end else if (!fInitN) begin
            shiftCnt_r <= '0;
        end else if (wrSer) begin
            shiftCnt_r <= (shiftCnt_r == (AW+1)'(2*AW-1)) ? '0 : shiftCnt_r + 1'b1;
        end
    end

    // Memory array written on enabled write edges
    logic [DCF_WIDTH-1:0] mem [DEPTH];
    always_ff @(posedge clk) begin
        if (wrMem) begin
            mem[wPtr_r[AW-1:0]] <= wData;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wPtr_r <= '0;
        end else if (initAny) begin
            wPtr_r <= '0;
        end else if (wrMem) begin
            wPtr_r <= wPtr_r + 1'b1;
        end
    end

    // Fall-through state: word on outputs and latency counter
    logic outValid_r;
    logic [1:0] ftWait_r;
    logic rdOff, rdMem, ftLoad;
    assign rdOff = rEdge && !rEnN && !ldN;
    assign rdMem = rEdge && !rEnN && ldN && !emptyNow && (!ftMode_r || outValid_r);
    // first word after three read clock transitions
    assign ftLoad = ftMode_r && !outValid_r && !emptyNow && rEdge &&
        ftWait_r == 2'(DCF_FT_LATENCY - 1);

    // Any read clock transition, rising or falling
    logic rTrans;
    assign rTrans = rClkS != rClkPrev_r;

    // Counts read clock transitions while a word waits to fall through
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ftWait_r <= '0;
        end else if (initAny || !ftMode_r || outValid_r || emptyNow) begin
            ftWait_r <= '0;
        end else if (rTrans && ftWait_r != 2'(DCF_FT_LATENCY - 1)) begin
            ftWait_r <= ftWait_r + 1'b1;
        end
    end

    logic rtHit;
    assign rtHit = rEdge && !rtN;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rPtr_r <= '0;
        end else if (initAny || rtHit) begin
            rPtr_r <= '0;
        end else if (rdMem || ftLoad) begin
            rPtr_r <= rPtr_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            outValid_r <= 1'b0;
        end else if (initAny || rtHit) begin
            outValid_r <= 1'b0;
        end else if (ftLoad) begin
            outValid_r <= 1'b1;
        end else if (ftMode_r && rEdge && !rEnN && ldN) begin
            outValid_r <= !emptyNow;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= DCF_DATA_RESET;
        end else if (initAny) begin
            rd_data <= DCF_DATA_RESET;
        end else if (rdOff) begin
            rd_data <= offRdSel_r ? DCF_WIDTH'(offFull_r) : DCF_WIDTH'(offEmpty_r);
        end else if (rdMem || ftLoad) begin
            rd_data <= mem[rPtr_r[AW-1:0]];
        end
    end

    // Offset read-back alternates empty then full
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            offRdSel_r <= 1'b0;
        end else if (initAny) begin
            offRdSel_r <= 1'b0;
        end else if (rdOff) begin
            offRdSel_r <= !offRdSel_r;
        end
    end

    // reread pulse held for one read clock
    logic rtHold_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rtHold_r <= 1'b0;
        end else if (rtHit) begin
            rtHold_r <= 1'b1;
        end else if (rEdge || initAny) begin
            rtHold_r <= 1'b0;
        end
    end

    // flags registered on the common sampling clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            full_or_input_ready <= 1'b1;
        end else begin
            full_or_input_ready <= ftMode_r ? fullNow : !fullNow;
        end
    end

    // reread overrides for one read edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            empty_or_output_ready <= 1'b0;
        end else if (rtHold_r) begin
            empty_or_output_ready <= ftMode_r;
        end else begin
            empty_or_output_ready <= ftMode_r ? !outValid_r : !emptyNow;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            almost_full_n <= 1'b1;
        end else begin
            almost_full_n <= !(count > (AW+1)'(DEPTH) - (AW+1)'(offFull_r));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            almost_empty_n <= 1'b0;
        end else begin
            almost_empty_n <= !(count < (AW+1)'(offEmpty_r));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            half_level_n <= 1'b1;
        end else begin
            half_level_n <= !(count > (AW+1)'(DEPTH / 2));
        end
    end

    // output enable on the data bus
    assign rdDataOe = !oeN;
endmodule // dcfifo_core
`default_nettype wire

/* File: verilog/dcfifo_pkg.sv */
// Constants for the dual-clock FIFO with programmable flags
`default_nettype none
package dcfifo_pkg;
    localparam int DCF_WIDTH = 18;
    localparam int DCF_DEPTH_SMALL = 131072;
    localparam int DCF_DEPTH_LARGE = 262144;
    localparam logic [17:0] DCF_OFFSET_NEAR = 18'h0007f;
    localparam logic [17:0] DCF_OFFSET_FAR = 18'h003ff;
    localparam logic [17:0] DCF_DATA_RESET = 18'h00000;
    localparam int DCF_FT_LATENCY = 3;
    localparam int DCF_SYNC_STAGES = 2;
    // Idle levels of the control pins, in synchroniser order, after reset
    localparam logic [11:0] DCF_SYNC_IDLE_CTRL = 12'hdae;
endpackage
`default_nettype wire
